//--- rtl/cpu_special_defines.svh
// register offsets, field positions, reset values and timing counts of the cpu special registers
`ifndef CPU_SPECIAL_DEFINES_SVH
`define CPU_SPECIAL_DEFINES_SVH
`define OFF_BANK_SELECT    12'h000
`define OFF_ACC            12'h004
`define OFF_PC_LOW         12'h008
`define OFF_TABLE_LOW      12'h00C
`define OFF_TABLE_HIGH     12'h010
`define OFF_TABLE_DATA     12'h014
`define OFF_FLAGS          12'h018
`define OFF_EXEC           12'h01C
`define OFF_OPERAND        12'h020
`define OFF_PC_FULL        12'h024
`define OFF_ROM_WORD       12'h028
`define FLAG_C             0
`define FLAG_AC            1
`define FLAG_Z             2
`define FLAG_OV            3
`define FLAG_PDF           4
`define FLAG_TO            5
`define FLAG_CZ            6
`define FLAG_SC            7
`define FLAGS_RESET        8'h00
`define FLAGS_SYS_MASK     8'h30
`define BANK_RESET         1'b0
`define PC_RESET           13'h0000
`define EXEC_OP_LSB        0
`define EXEC_OP_MSB        3
`define EXEC_TABLE_DST_BIT 8
`define PC_JUMP_DUMMY      2'd1
`endif

//--- rtl/cpu_special_pkg.sv
// types shared by the cpu special register block
package cpu_special_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
    OP_RLC, OP_RRC, OP_MOV, OP_TABRD, OP_CLRWDT, OP_HALT, OP_WDTEXP, OP_RSV
  } alu_op_t;
  typedef struct packed {
    logic       sc;
    logic       cz;
    logic       to;
    logic       power_down_flag;
    logic       ov;
    logic       z;
    logic       ac;
    logic       c;
  } cpu_flags_t;
  typedef struct packed {
    logic       carry;
    logic       nib_carry;
    logic       msb_carry_in;
    logic [7:0] value;
  } alu_result_t;
endpackage

//--- rtl/cpu_status_and_pointer_regs.sv
// cpu special registers: bank select, accumulator, pc low byte, table pointers and flags, apb reachable
// Functional notes
// - bank bit picks branch target bank, resets 0
// - bank select upper bits read zero
// - pc low write jumps in page, dummy cycle
// - table read splits word to high/destination
// - flag writes keep timeout and power down
// - timeout set on expiry, cleared clrwdt/halt
// - power down set by halt, cleared clrwdt
// - carry from add, no-borrow, rotates
// - nibble carry from low nibble
// - zero flag on zero result
// - overflow is carry-in xor carry-out msb
// - signed compare is overflow xor msb
// - plain subtract copies zero into chained
// - borrow subtract ands chained with zero
// - other instructions keep chained zero
// - calls never save the flags
// - timeout and power down reset zero
// - every alu result lands in accumulator
// - data eeprom not in this space
`timescale 1ns/100ps
`include "cpu_special_defines.svh"
module cpu_status_and_pointer_regs
  import cpu_special_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // program fetch side
  output logic      [12:0] pc_out,
  output logic             bank_choice_bit,
  output logic             dummy_cycle
);

  // apb decode
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & ~penable & ~pwrite;
  wire hit_bank  = paddr == `OFF_BANK_SELECT;
  wire hit_acc   = paddr == `OFF_ACC;
  wire hit_pcl   = paddr == `OFF_PC_LOW;
  wire hit_tbl   = paddr == `OFF_TABLE_LOW;
  wire hit_tbh   = paddr == `OFF_TABLE_HIGH;
  wire hit_tbd   = paddr == `OFF_TABLE_DATA;
  wire hit_flags = paddr == `OFF_FLAGS;
  wire hit_exec  = paddr == `OFF_EXEC;
  wire hit_opnd  = paddr == `OFF_OPERAND;
  wire hit_pcf   = paddr == `OFF_PC_FULL;
  wire hit_rom   = paddr == `OFF_ROM_WORD;
  wire mapped = hit_bank | hit_acc | hit_pcl | hit_tbl | hit_tbh | hit_tbd | hit_flags
              | hit_exec | hit_opnd | hit_pcf | hit_rom;

  logic        bank_r;
  logic [7:0]  acc_r;
  logic [12:0] pc_r;
  logic [7:0]  tbl_r;
  logic [7:0]  tbh_r;
  logic [7:0]  tbd_r;
  logic [7:0]  opnd_r;
  logic [7:0]  dest_r;
  logic [15:0] rom_r;
  cpu_flags_t  flags_r;
  logic [1:0]  dummy_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [31:0] prdata_nxt;
  // registered copies of the fetch side outputs and the bus ready
  logic [12:0] pc_out_r;
  logic        dummy_cycle_r;
  logic        pready_r;

  // executing an instruction is a write to the exec register
  wire       exec_go  = apb_wr & hit_exec;
  alu_op_t   op;
  assign op = alu_op_t'(pwdata[`EXEC_OP_MSB:`EXEC_OP_LSB]);
  wire       tab_to_acc = pwdata[`EXEC_TABLE_DST_BIT];
  wire       tab_go     = exec_go & (op == OP_TABRD);

  // alu: subtraction as a + ~b + carry so carries mean "no borrow"
  wire       is_sub   = (op == OP_SUB) | (op == OP_SBC);
  wire [7:0] b_in     = is_sub ? ~opnd_r : opnd_r;
  wire       cin      = (op == OP_SUB) ? 1'b1 : ((op == OP_ADC) | (op == OP_SBC)) ? flags_r.c : 1'b0;
  wire [4:0] lo_sum   = {1'b0, acc_r[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
  wire [3:0] mid_sum  = {1'b0, acc_r[6:4]} + {1'b0, b_in[6:4]} + {3'h0, lo_sum[4]};
  wire [1:0] top_sum  = {1'b0, acc_r[7]} + {1'b0, b_in[7]} + {1'b0, mid_sum[3]};
  wire [7:0] sum      = {top_sum[0], mid_sum[2:0], lo_sum[3:0]};
  wire       arith    = (op == OP_ADD) | (op == OP_ADC) | is_sub;
  wire       logic_op = (op == OP_AND) | (op == OP_OR) | (op == OP_XOR);
  wire       rot_op   = (op == OP_RLC) | (op == OP_RRC);
  alu_result_t res;
  assign res.value = arith ? sum :
                     (op == OP_AND) ? (acc_r & opnd_r) :
                     (op == OP_OR)  ? (acc_r | opnd_r) :
                     (op == OP_XOR) ? (acc_r ^ opnd_r) :
                     (op == OP_RLC) ? {acc_r[6:0], flags_r.c} :
                     (op == OP_RRC) ? {flags_r.c, acc_r[7:1]} :
                     opnd_r;
  assign res.carry        = (op == OP_RLC) ? acc_r[7] : (op == OP_RRC) ? acc_r[0] : top_sum[1];
  assign res.nib_carry    = lo_sum[4];
  assign res.msb_carry_in = mid_sum[3];
  wire res_zero = res.value == 8'h00;
  wire ov_new   = res.msb_carry_in ^ res.carry;

  // flag next value
  cpu_flags_t flags_alu;
  always_comb begin
    flags_alu = flags_r;
    if (arith) begin
      flags_alu.c  = res.carry;
      flags_alu.ac = res.nib_carry;
      flags_alu.ov = ov_new;
      flags_alu.sc = ov_new ^ res.value[7];
    end
    if (rot_op) begin
      flags_alu.c = res.carry;
    end
    if (arith | logic_op) begin
      flags_alu.z = res_zero;
    end
    if (op == OP_SUB) begin
      flags_alu.cz = res_zero;
    end else if (op == OP_SBC) begin
      flags_alu.cz = flags_r.cz & res_zero;
    end
    // other ops leave cz as it was
    if (op == OP_CLRWDT) begin
      flags_alu.to  = 1'b0;
      flags_alu.power_down_flag = 1'b0;
    end
    if (op == OP_HALT) begin
      flags_alu.to  = 1'b0;
      flags_alu.power_down_flag = 1'b1;
    end
    if (op == OP_WDTEXP) begin
      flags_alu.to = 1'b1;
    end
  end

  // software flag write keeps the two system flags
  wire [7:0] flags_sw = (pwdata[7:0] & ~`FLAGS_SYS_MASK) | (flags_r & `FLAGS_SYS_MASK);
  wire [7:0] flags_nxt = exec_go ? flags_alu :
                         (apb_wr & hit_flags) ? flags_sw : flags_r;
  wire       writes_acc = arith | logic_op | rot_op | (op == OP_MOV) | ((op == OP_TABRD) & tab_to_acc);
  // a table read aimed at the destination register must leave the accumulator untouched
  wire [7:0] acc_nxt = (tab_go & tab_to_acc) ? rom_r[7:0] :
                       (exec_go & writes_acc) ? res.value :
                       (apb_wr & hit_acc) ? pwdata[7:0] : acc_r;

  // flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // accumulator and operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= 8'h00;
      opnd_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      if (apb_wr & hit_opnd) begin
        opnd_r <= pwdata[7:0];
      end
    end
  end

  // bank select and program counter next values
  wire        wr_bank   = apb_wr & hit_bank;
  wire        wr_pcl    = apb_wr & hit_pcl;
  wire        wr_pcf    = apb_wr & hit_pcf;
  wire        bank_nxt  = wr_bank ? pwdata[0] : bank_r;
  // a pc low write only swaps the low byte, so a computed jump cannot leave its page
  wire [12:0] pc_nxt    = wr_pcl ? {pc_r[12:8], pwdata[7:0]} :
                          wr_pcf ? pwdata[12:0] : pc_r;
  wire [1:0]  dummy_nxt = wr_pcl ? `PC_JUMP_DUMMY :
                          wr_pcf ? 2'h0 :
                          (dummy_r != 2'h0) ? (dummy_r - 2'h1) : 2'h0;

  // bank select; only bit 0 exists, so the upper bits can never hold a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_r <= `BANK_RESET;
    end else begin
      bank_r <= bank_nxt;
    end
  end

  // program counter and dummy slot counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r    <= `PC_RESET;
      dummy_r <= 2'h0;
    end else begin
      pc_r    <= pc_nxt;
      dummy_r <= dummy_nxt;
    end
  end

  // fetch side outputs are registered from the next values, so they never lag the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_out_r      <= `PC_RESET;
      dummy_cycle_r <= 1'b0;
    end else begin
      pc_out_r      <= {bank_nxt, pc_nxt[11:0]};
      dummy_cycle_r <= dummy_nxt != 2'h0;
    end
  end

  // table pointers, fetched rom word and high byte holder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_r  <= 8'h00;
      tbh_r  <= 8'h00;
      tbd_r  <= 8'h00;
      rom_r  <= 16'h0000;
      dest_r <= 8'h00;
    end else begin
      if (apb_wr & hit_tbl) begin
        tbl_r <= pwdata[7:0];
      end
      if (apb_wr & hit_tbh) begin
        tbh_r <= pwdata[7:0];
      end
      if (apb_wr & hit_rom) begin
        rom_r <= pwdata[15:0];
      end
      if (tab_go) begin
        tbd_r <= rom_r[15:8];
        if (!tab_to_acc) begin
          dest_r <= rom_r[7:0];
        end
      end
    end
  end

  // read mux; rom word register reads back the table address in its upper half
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (hit_bank)  prdata_nxt = {31'h0, bank_r};
    if (hit_acc)   prdata_nxt = {24'h0, acc_r};
    if (hit_pcl)   prdata_nxt = {24'h0, pc_r[7:0]};
    if (hit_tbl)   prdata_nxt = {24'h0, tbl_r};
    if (hit_tbh)   prdata_nxt = {24'h0, tbh_r};
    if (hit_tbd)   prdata_nxt = {24'h0, tbd_r};
    if (hit_flags) prdata_nxt = {24'h0, flags_r};
    if (hit_opnd)  prdata_nxt = {24'h0, dest_r};
    if (hit_pcf)   prdata_nxt = {19'h0, pc_r};
    if (hit_rom)   prdata_nxt = {tbh_r, tbl_r, rom_r};
  end

  // apb answer: zero wait, error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pready_r  <= 1'b0;
    end else begin
      if (apb_rd) begin
        prdata_r <= prdata_nxt;
      end
      pslverr_r <= psel & ~penable & ~mapped;
      pready_r  <= psel & ~penable;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign pc_out          = pc_out_r;
  assign bank_choice_bit = bank_r;
  assign dummy_cycle     = dummy_cycle_r;
  // no path stores flags on call; no eeprom decode here

  chk_sys_flags_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr & hit_flags) |=> (flags_r[5:4] == $past(flags_r[5:4])))
    else $error("system flags changed by flag write");
  chk_halt_sets_pdf: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_HALT) |=> (flags_r.power_down_flag && !flags_r.to))
    else $error("halt did not set power down");
  chk_clrwdt_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_CLRWDT) |=> (!flags_r.power_down_flag && !flags_r.to))
    else $error("clear watchdog left a flag");
  chk_wdt_sets_to: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_WDTEXP) |=> flags_r.to)
    else $error("timeout flag not set");
  chk_sub_cz_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_SUB) |=> (flags_r.cz == flags_r.z))
    else $error("chained zero differs after subtract");
  chk_sbc_cz_and: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_SBC) |=> (flags_r.cz == ($past(flags_r.cz) & flags_r.z)))
    else $error("chained zero not anded");
  chk_other_cz_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op != OP_SUB & op != OP_SBC) |=> $stable(flags_r.cz))
    else $error("chained zero changed");
  chk_sc_relation: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & arith) |=> (flags_r.sc == (flags_r.ov ^ acc_r[7])))
    else $error("signed compare mismatch");
  chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & (arith | logic_op)) |=> (flags_r.z == (acc_r == 8'h00)))
    else $error("zero flag mismatch");
  chk_pcl_page: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr & hit_pcl) |=> (pc_r[12:8] == $past(pc_r[12:8]) && dummy_cycle) ##1 !dummy_cycle)
    else $error("pc low jump left page or dummy wrong");
  chk_bank_upper: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_rd & hit_bank) |=> (prdata_r[31:1] == 31'h0))
    else $error("bank select upper bits nonzero");

  // reference sums built straight from the operands, independent of the split adder above
  wire [8:0] add_ref = {1'b0, acc_r} + {1'b0, opnd_r};
  wire [8:0] sub_ref = {1'b0, acc_r} - {1'b0, opnd_r};
  wire [4:0] nib_ref = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};

  chk_bank_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_bank |=> (bank_r == $past(pwdata[0])))
    else $error("bank select write lost");
  chk_fetch_bank: assert property (@(posedge pclk) disable iff (!presetn)
    pc_out == {bank_r, pc_r[11:0]})
    else $error("fetch address ignores bank select");
  chk_pcl_low: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pcl |=> (pc_r[7:0] == $past(pwdata[7:0])))
    else $error("pc low byte not loaded");
  chk_dummy_single: assert property (@(posedge pclk) disable iff (!presetn)
    dummy_cycle |=> !dummy_cycle)
    else $error("dummy slot longer than one cycle");
  chk_dummy_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dummy_cycle) |-> $past(wr_pcl))
    else $error("dummy slot without pc low write");
  chk_tab_high: assert property (@(posedge pclk) disable iff (!presetn)
    tab_go |=> (tbd_r == $past(rom_r[15:8])))
    else $error("table high byte not stored");
  chk_tab_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (tab_go & !tab_to_acc) |=> (dest_r == $past(rom_r[7:0]) && $stable(acc_r)))
    else $error("table low byte misrouted");
  chk_tab_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (tab_go & tab_to_acc) |=> (acc_r == $past(rom_r[7:0])))
    else $error("table low byte not in accumulator");
  chk_add_carry: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_ADD) |=> ({flags_r.c, acc_r} == $past(add_ref)))
    else $error("add carry or sum wrong");
  chk_adc_carry: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_ADC) |=> ({flags_r.c, acc_r} == $past(add_ref) + $past(flags_r.c)))
    else $error("add with carry wrong");
  chk_sub_borrow: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_SUB) |=> ({!flags_r.c, acc_r} == $past(sub_ref)))
    else $error("subtract borrow or difference wrong");
  chk_sbc_borrow: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_SBC) |=> ({!flags_r.c, acc_r} == $past(sub_ref) - {8'h00, !$past(flags_r.c)}))
    else $error("subtract with borrow wrong");
  chk_add_nibble: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_ADD) |=> (flags_r.ac == $past(nib_ref[4])))
    else $error("nibble carry wrong");
  chk_add_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_ADD) |=> (flags_r.ov ==
      (($past(acc_r[7]) == $past(opnd_r[7])) && (acc_r[7] != $past(acc_r[7])))))
    else $error("overflow flag wrong");
  chk_rlc_carry: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_RLC) |=> (flags_r.c == $past(acc_r[7]) && acc_r == {$past(acc_r[6:0]), $past(flags_r.c)}))
    else $error("rotate through carry wrong");
  chk_mov_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_go & op == OP_MOV) |=> (acc_r == $past(opnd_r)))
    else $error("move did not pass through accumulator");
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel & ~penable & ~mapped) |=> pslverr)
    else $error("unmapped access not refused");
endmodule

//--- tb/fetch_side_model.sv
// program fetch side model: watches the fetch address and counts pc low jumps
`timescale 1ns/100ps
module fetch_side_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // fetch side
  input  wire logic [12:0] pc_out,
  input  wire logic        dummy_cycle,
  // observations
  output logic      [7:0]  dummy_count,
  output logic      [12:0] jump_target
);
  // the dummy slot is where fetch drops its prefetched word and restarts at pc_out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dummy_count <= 8'h00;
      jump_target <= 13'h0000;
    end else if (dummy_cycle) begin
      dummy_count <= dummy_count + 8'h01;
      jump_target <= pc_out;
    end
  end
endmodule

//--- tb/cpu_status_and_pointer_regs_tb_top.sv
// self-checking bench for the cpu special registers
`timescale 1ns/100ps
`include "cpu_special_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t: got %h want %h", $time, g, e); end end
module cpu_status_and_pointer_regs_tb_top;
  import cpu_special_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, bank_choice_bit, dummy_cycle;
  logic [12:0] pc_out, jump_target;
  logic [7:0]  dummy_count, a, b, res;
  logic [3:0]  op;
  logic [32:0] me, expq[$];
  cpu_flags_t  f, nf;
  int          n_mismatch = 0, num_checks = 0, seed = 32'h0fef28f7;
  logic [11:0] sys_tab [5] = '{12'hDDF, 12'hEFF, 12'hDDF, 12'hCCF, 12'hEEF};

  always #2.5 pclk = ~pclk;

  cpu_status_and_pointer_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pc_out(pc_out), .bank_choice_bit(bank_choice_bit), .dummy_cycle(dummy_cycle));
  fetch_side_model far (.pclk(pclk), .presetn(presetn), .pc_out(pc_out), .dummy_cycle(dummy_cycle),
    .dummy_count(dummy_count), .jump_target(jump_target));

  task wrap_up;
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer followed by an idle cycle, so exec results have landed before the next setup
  task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    expq.push_back(e);
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        wrap_up;
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, 33'h0);
  endtask

  task rd(input logic [11:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0, {1'b0, e});
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      me = expq.pop_front();
      `CHK(pslverr, me[32])
      if (!pwrite) `CHK(prdata, me[31:0])
    end
  end

  function automatic void alu(input logic [3:0] o, input logic [7:0] x, y, input cpu_flags_t fi,
                              output logic [7:0] r, output cpu_flags_t fo);
    logic [8:0] s;
    logic [7:0] yy;
    logic       ci;
    fo = fi;
    yy = (o == 4'd3 || o == 4'd4) ? ~y : y;
    ci = (o == 4'd3) | ((o == 4'd2 || o == 4'd4) & fi.c);
    s = x + yy + ci;
    r = y;
    if (o <= 4'd4) begin
      r = s[7:0];
      fo.c = s[8];
      fo.ac = ({1'b0, x[3:0]} + yy[3:0] + ci) > 5'd15;
      fo.ov = s[8] ^ x[7] ^ yy[7] ^ s[7];
      fo.z = (r == 8'h00);
      fo.sc = fo.ov ^ r[7];
      if (o == 4'd3) fo.cz = fo.z;
      if (o == 4'd4) fo.cz = fi.cz & fo.z;
    end else if (o <= 4'd7) begin
      r = (o == 4'd5) ? (x & y) : (o == 4'd6) ? (x | y) : (x ^ y);
      fo.z = (r == 8'h00);
    end else if (o == 4'd8) begin
      r = {x[6:0], fi.c};
      fo.c = x[7];
    end else if (o == 4'd9) begin
      r = {fi.c, x[7:1]};
      fo.c = x[0];
    end
  endfunction

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFF_FLAGS, 32'h0);
    rd(`OFF_BANK_SELECT, 32'h0);
    wr(`OFF_BANK_SELECT, 32'hFF);
    rd(`OFF_BANK_SELECT, 32'h1);
    `CHK(bank_choice_bit, 1'b1)
    wr(`OFF_FLAGS, 32'hFF);
    rd(`OFF_FLAGS, 32'hCF);
    foreach (sys_tab[i]) begin
      wr(`OFF_EXEC, {28'h0, sys_tab[i][11:8]});
      rd(`OFF_FLAGS, {24'h0, sys_tab[i][7:0]});
    end
    wr(`OFF_FLAGS, 32'h0);
    rd(`OFF_FLAGS, 32'h20);
    wr(`OFF_EXEC, 32'hC);
    rd(`OFF_FLAGS, 32'h0);
    wr(`OFF_PC_LOW, 32'h5A);
    repeat (3) @(posedge pclk);
    `CHK(dummy_count, 8'd1)
    `CHK({jump_target[12], jump_target[7:0]}, 9'h15A)
    wr(`OFF_PC_FULL, 32'h0ABC);
    rd(`OFF_PC_FULL, 32'h0ABC);
    wr(`OFF_PC_LOW, 32'hA5);
    rd(`OFF_PC_FULL, 32'h0AA5);
    rd(`OFF_PC_LOW, 32'hA5);
    `CHK(dummy_count, 8'h02)
    `CHK(jump_target, 13'h1AA5)
    wr(`OFF_TABLE_LOW, 32'h34);
    wr(`OFF_TABLE_HIGH, 32'h12);
    wr(`OFF_ROM_WORD, 32'hABCD);
    wr(`OFF_EXEC, 32'h10B);
    rd(`OFF_ACC, 32'hCD);
    rd(`OFF_TABLE_DATA, 32'hAB);
    wr(`OFF_ROM_WORD, 32'h9E71);
    wr(`OFF_EXEC, 32'h00B);
    rd(`OFF_OPERAND, 32'h71);
    rd(`OFF_TABLE_DATA, 32'h9E);
    rd(`OFF_ACC, 32'hCD);
    rd(`OFF_ROM_WORD, 32'h12349E71);
    repeat (60) begin
      op = 4'(1 + {$random(seed)} % 10);
      a = 8'($random(seed));
      b = 8'($random(seed));
      f = cpu_flags_t'($random(seed));
      f.to = 1'b0;
      f.power_down_flag = 1'b0;
      wr(`OFF_FLAGS, {24'h0, f});
      wr(`OFF_ACC, {24'h0, a});
      wr(`OFF_OPERAND, {24'h0, b});
      wr(`OFF_EXEC, {28'h0, op});
      alu(op, a, b, f, res, nf);
      rd(`OFF_ACC, {24'h0, res});
      rd(`OFF_FLAGS, {24'h0, nf});
    end
    wr(`OFF_EXEC, 32'h0);
    wr(`OFF_EXEC, 32'hF);
    rd(`OFF_ACC, {24'h0, res});
    rd(`OFF_FLAGS, {24'h0, nf});
    xfer(1'b1, 12'h0FC, 32'hFF, {1'b1, 32'h0});
    xfer(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
    wrap_up;
  end
endmodule
